// [txp_parser.sv]
// Purpose: parse the two-word transmit command ahead of each buffer
// Assumes: host words arrive on in_valid/in_data, one per cycle at most
// Notes:   only payload-bearing words reach the data FIFO
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module txp_parser (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset,
   // host words into the transmit data path
   input  wire logic                in_valid,
   input  wire logic [31:0]         in_data,
   // words to the data FIFO
   output logic                     out_valid,
   output txp_pkg::txp_word_t       out_word,
   // packet status
   output logic                     stat_valid,
   output txp_pkg::txp_stat_t       stat,
   // flags
   output logic                     tx_done_flag,
   output logic                     tx_error_flag,
   output logic                     irq,
   // register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata
);
   import txp_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   txp_state_t          state_ff, nxt_state;
   txp_cmd_a_t          cmda_ff, nxt_cmda;
   txp_cmd_b_t          pktb_ff, nxt_pktb;
   logic [10:0]         sum_ff, nxt_sum;
   logic                open_ff, nxt_open;
   logic [WIDX_W-1:0]   widx_ff, nxt_widx;
   logic                ov_ff, nxt_ov;
   txp_word_t           ow_ff, nxt_ow;
   logic                sv_ff, nxt_sv;
   txp_stat_t           st_ff, nxt_st;
   logic                done_ff, nxt_done;
   logic                err_ff, nxt_err;
   logic [15:0]         cnt_ff, nxt_cnt;
   logic [15:0]         tag_ff, nxt_tag;
   logic [31:0]         rd_ff, nxt_rd;
   logic [WIDX_W-1:0]   words;
   logic                buf_end;
   logic [NUM_EV-1:0]   sts, en;

   txp_span u_span (
      .offset (cmda_ff.offset),
      .size   (cmda_ff.size),
      .align  (cmda_ff.align),
      .words  (words)
   );

   // byte lanes of word widx that fall inside [offset, offset+size)
   function automatic logic [3:0] lanes(input logic [WIDX_W-1:0] widx,
                                        input logic [4:0] off,
                                        input logic [10:0] size);
      logic [11:0] b;
      logic [11:0] lim;
      lanes = 4'h0;
      lim   = 12'({7'h0, off} + {1'b0, size});
      for (int l = 0; l < 4; l++) begin
         b = 12'({widx, 2'b00} + 12'(l));
         lanes[l] = (b >= {7'h0, off}) && (b < lim);
      end
   endfunction : lanes

   // ***************************************************
   // command and data parsing
   // ***************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_cmda  = cmda_ff;
      nxt_pktb  = pktb_ff;
      nxt_sum   = sum_ff;
      nxt_open  = open_ff;
      nxt_widx  = widx_ff;
      nxt_ov    = 1'b0;
      nxt_ow    = ow_ff;
      nxt_sv    = 1'b0;
      nxt_st    = st_ff;
      nxt_done  = 1'b0;
      nxt_err   = 1'b0;
      nxt_cnt   = cnt_ff;
      nxt_tag   = tag_ff;
      buf_end   = 1'b0;
      case (state_ff)
         ST_A: begin
            if (in_valid) begin
               nxt_cmda  = txp_cmd_a_t'(in_data);
               nxt_state = ST_B;
            end
         end
         ST_B: begin
            if (in_valid) begin
               nxt_widx = '0;
               if (cmda_ff.first_segment_bit) begin
                  // a packet left open is broken by a new first buffer
                  if (open_ff) nxt_err = 1'b1;
                  nxt_pktb = txp_cmd_b_t'(in_data);
                  nxt_sum  = cmda_ff.size;
                  nxt_open = 1'b1;
               end else begin
                  if (!open_ff || in_data != 32'(pktb_ff)) begin
                     nxt_err = 1'b1;
                  end
                  nxt_sum = 11'(sum_ff + cmda_ff.size);
               end
               if (words == '0) begin
                  buf_end   = 1'b1;
                  nxt_state = ST_A;
               end else begin
                  nxt_state = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (in_valid) begin
               nxt_ow.data = in_data;
               nxt_ow.be   = lanes(widx_ff, cmda_ff.offset, cmda_ff.size);
               // offset and pad words carry no lane and are dropped
               nxt_ov = |nxt_ow.be;
               if (nxt_ov) nxt_cnt = 16'(cnt_ff + 16'h0001);
               nxt_widx = WIDX_W'(widx_ff + 1'b1);
               if (widx_ff == WIDX_W'(words - 1'b1)) begin
                  buf_end   = 1'b1;
                  nxt_state = ST_A;
               end
            end
         end
         default: nxt_state = ST_A;
      endcase
      if (buf_end) begin
         nxt_done = cmda_ff.ioc;
         if (cmda_ff.last) begin
            if (nxt_sum != nxt_pktb.len) nxt_err = 1'b1;
            nxt_sv     = 1'b1;
            nxt_st.tag = nxt_pktb.tag;
            nxt_st.err = nxt_err;
            nxt_tag    = nxt_pktb.tag;
            nxt_open   = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_ff <= ST_A;
         cmda_ff  <= '0;
         pktb_ff  <= '0;
         sum_ff   <= '0;
         open_ff  <= 1'b0;
         widx_ff  <= '0;
         ov_ff    <= 1'b0;
         ow_ff    <= '0;
         sv_ff    <= 1'b0;
         st_ff    <= '0;
         done_ff  <= 1'b0;
         err_ff   <= 1'b0;
         cnt_ff   <= '0;
         tag_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         cmda_ff  <= nxt_cmda;
         pktb_ff  <= nxt_pktb;
         sum_ff   <= nxt_sum;
         open_ff  <= nxt_open;
         widx_ff  <= nxt_widx;
         ov_ff    <= nxt_ov;
         ow_ff    <= nxt_ow;
         sv_ff    <= nxt_sv;
         st_ff    <= nxt_st;
         done_ff  <= nxt_done;
         err_ff   <= nxt_err;
         cnt_ff   <= nxt_cnt;
         tag_ff   <= nxt_tag;
      end
   end

   assign out_valid     = ov_ff;
   assign out_word      = ow_ff;
   assign stat_valid    = sv_ff;
   assign stat          = st_ff;
   assign tx_done_flag  = done_ff;
   assign tx_error_flag = err_ff;

   // ***************************************************
   // registers and interrupt
   // ***************************************************
   txp_irq #(.N(NUM_EV)) u_irq (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ev      ({err_ff, done_ff}),
      .clr_wr  (reg_wr && reg_addr == REG_INT_CLR),
      .en_wr   (reg_wr && reg_addr == REG_INT_EN),
      .wdata   (reg_wdata[NUM_EV-1:0]),
      .sts     (sts),
      .en      (en),
      .irq     (irq)
   );

   always_comb begin
      nxt_rd = 32'h0;
      if (reg_rd) begin
         if (reg_addr == REG_INT_STS) nxt_rd = 32'(sts);
         else if (reg_addr == REG_INT_EN) nxt_rd = 32'(en);
         else if (reg_addr == REG_WORDS) nxt_rd = 32'(cnt_ff);
         else if (reg_addr == REG_TAG) nxt_rd = {15'h0, open_ff, tag_ff};
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) rd_ff <= 32'h0;
      else rd_ff <= nxt_rd;
   end

   assign reg_rdata = rd_ff;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   property p_cmd_order;
      state_ff == ST_A && in_valid |=> state_ff == ST_B;
   endproperty
   a_cmd_order: assert property (p_cmd_order) else $error("no B after A");

   property p_b_mismatch;
      state_ff == ST_B && in_valid && !cmda_ff.first_segment_bit && open_ff
         && in_data != 32'(pktb_ff) |=> tx_error_flag;
   endproperty
   a_b_mismatch: assert property (p_b_mismatch) else $error("B mismatch");

   property p_tag;
      stat_valid |-> stat.tag == tag_ff && stat.tag == pktb_ff.tag;
   endproperty
   a_tag: assert property (p_tag) else $error("status tag wrong");

   property p_done;
      tx_done_flag |-> $past(cmda_ff.ioc) && $past(state_ff) != ST_A;
   endproperty
   a_done: assert property (p_done) else $error("done without ioc");

   property p_stored;
      out_valid |-> out_word.be != 4'h0 && cnt_ff != $past(cnt_ff);
   endproperty
   a_stored: assert property (p_stored) else $error("empty word stored");

   property p_offset;
      state_ff == ST_DATA && in_valid && widx_ff == '0
         && cmda_ff.offset >= 5'h04 |=> !out_valid;
   endproperty
   a_offset: assert property (p_offset) else $error("offset word kept");

   property p_first;
      state_ff == ST_B && in_valid && cmda_ff.first_segment_bit
         |=> sum_ff == $past(cmda_ff.size) && (open_ff || $past(cmda_ff.last));
   endproperty
   a_first: assert property (p_first) else $error("sum not restarted");

   property p_len;
      buf_end && cmda_ff.last && nxt_sum != nxt_pktb.len
         |=> tx_error_flag && stat_valid && stat.err;
   endproperty
   a_len: assert property (p_len) else $error("length error missed");

   property p_align;
      state_ff == ST_DATA && in_valid && widx_ff == WIDX_W'(words - 1'b1)
         |=> state_ff == ST_A ##1 (state_ff != ST_DATA);
   endproperty
   a_align: assert property (p_align) else $error("pad not consumed");

   c_good_pkt: cover property (stat_valid && !stat.err);
   c_err_pkt:  cover property (stat_valid && stat.err);
   c_done_irq: cover property (tx_done_flag ##1 irq);

endmodule : txp_parser

// [txp_pkg.sv]
// Purpose: shared types and constants of the transmit command parser
// Assumes: 32-bit host words, one word per write
// Notes:   command layouts are packed structs, msb first
package txp_pkg;

   // ***************************************************
   // command words
   // ***************************************************
   typedef struct packed {
      logic        ioc;        // 31
      logic [4:0]  rsv_hi;     // 30:26
      logic [1:0]  align;      // 25:24
      logic [2:0]  rsv_mid;    // 23:21
      logic [4:0]  offset;     // 20:16
      logic [1:0]  rsv_lo;     // 15:14
      logic        first_segment_bit; // 13
      logic        last;       // 12
      logic        rsv_b11;    // 11
      logic [10:0] size;       // 10:0
   } txp_cmd_a_t;

   typedef struct packed {
      logic [15:0] tag;        // 31:16
      logic [4:0]  rsv;        // 15:11
      logic [10:0] len;        // 10:0
   } txp_cmd_b_t;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  be;
   } txp_word_t;

   typedef struct packed {
      logic [15:0] tag;
      logic        err;
   } txp_stat_t;

   typedef enum logic [1:0] {
      ST_A    = 2'b00,
      ST_B    = 2'b01,
      ST_DATA = 2'b10
   } txp_state_t;

   // ***************************************************
   // end alignment codes
   // ***************************************************
   localparam logic [1:0] ALIGN_4  = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;

   // ***************************************************
   // register map and fields
   // ***************************************************
   localparam logic [7:0] REG_INT_STS = 8'h00;
   localparam logic [7:0] REG_INT_CLR = 8'h04;
   localparam logic [7:0] REG_INT_EN  = 8'h08;
   localparam logic [7:0] REG_WORDS   = 8'h0c;
   localparam logic [7:0] REG_TAG     = 8'h10;
   localparam int         EV_DONE     = 0;
   localparam int         EV_ERR      = 1;
   localparam int         NUM_EV      = 2;
   localparam logic [1:0] INT_EN_RST  = 2'h0;
   localparam int         OPEN_BIT    = 16;
   localparam int         WIDX_W      = 10;

endpackage : txp_pkg

// [txp_span.sv]
// Purpose: number of words the host writes for one buffer
// Assumes: fields taken from a latched command A
// Notes:   purely combinational
`timescale 1ns/1ps
module txp_span (
   // command fields
   input  wire logic [4:0]              offset,
   input  wire logic [10:0]             size,
   input  wire logic [1:0]              align,
   // result
   output logic [txp_pkg::WIDX_W-1:0]   words
);
   import txp_pkg::*;

   logic [11:0] raw;

   always_comb begin
      raw = (12'({7'h0, offset} + {1'b0, size} + 12'h003)) >> 2;
      // code 11 is unsupported; it falls back to 4-byte handling
      case (align)
         ALIGN_16: words = WIDX_W'(((raw + 12'h003) >> 2) << 2);
         ALIGN_32: words = WIDX_W'(((raw + 12'h007) >> 3) << 3);
         default:  words = WIDX_W'(raw);
      endcase
   end

endmodule : txp_span

// [txp_irq.sv]
// Purpose: sticky event status, enable mask and level interrupt
// Assumes: events are one-cycle pulses on sys_clk
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
module txp_irq #(
   parameter int N = 2
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          reset,
   // events and software access
   input  wire logic [N-1:0]  ev,
   input  wire logic          clr_wr,
   input  wire logic          en_wr,
   input  wire logic [N-1:0]  wdata,
   // state
   output logic [N-1:0]       sts,
   output logic [N-1:0]       en,
   output logic               irq
);
   import txp_pkg::*;

   logic [N-1:0] sts_ff, nxt_sts, en_ff, nxt_en;
   logic         irq_ff, nxt_irq;

   always_comb begin
      nxt_sts = (sts_ff & ~(clr_wr ? wdata : '0)) | ev;
      nxt_en  = en_wr ? wdata : en_ff;
      nxt_irq = |(nxt_sts & nxt_en);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sts_ff <= '0;
         en_ff  <= N'(INT_EN_RST);
         irq_ff <= 1'b0;
      end else begin
         sts_ff <= nxt_sts;
         en_ff  <= nxt_en;
         irq_ff <= nxt_irq;
      end
   end

   assign sts = sts_ff;
   assign en  = en_ff;
   assign irq = irq_ff;

endmodule : txp_irq

// [txp_host_model.sv]
// Purpose: host side that writes transmit buffers into the parser
// Assumes: one word per clock, caller builds both command words
// Notes:   idle data lines show the inverse of the last word
`timescale 1ns/1ps
module txp_host_model (
   // clock
   input  wire logic    sys_clk,
   // host word stream
   output logic         in_valid,
   output logic [31:0]  in_data
);
   import txp_pkg::*;

   initial begin
      in_valid = 1'b0;
      in_data  = 32'h0;
   end

   function automatic int span(input int off, input int sz,
                               input logic [1:0] al);
      int w;
      w = (off + sz + 3) / 4;
      if (al == ALIGN_16) w = (w + 3) / 4 * 4;
      if (al == ALIGN_32) w = (w + 7) / 8 * 8;
      return w;
   endfunction : span

   task automatic put(input logic [31:0] d);
      @(posedge sys_clk);
      in_valid <= 1'b1;
      in_data  <= d;
   endtask : put

   task automatic send_buf(input txp_cmd_a_t a, input txp_cmd_b_t b,
                           input logic [31:0] base);
      int n;
      a.rsv_hi = 5'h00;
      if (a.align == 2'h3) a.align = ALIGN_4;
      n = span(a.offset, a.size, a.align);
      put(a);
      put(b);
      for (int i = 0; i < n; i++) put(base + i);
      @(posedge sys_clk);
      in_valid <= 1'b0;
      in_data  <= ~in_data;
   endtask : send_buf
endmodule : txp_host_model

// [tb_tx_buffer_command_parser.sv]
// Purpose: self-checking bench of the transmit command parser
// Assumes: host model drives the word stream, bench the register port
// Notes:   expectations come from offset and size arithmetic
`timescale 1ns/1ps
module tb_tx_buffer_command_parser;
   import txp_pkg::*;
   logic         sys_clk, reset, in_valid, reg_wr, reg_rd;
   logic [31:0]  in_data, reg_wdata, reg_rdata, first_data;
   logic [7:0]   reg_addr;
   logic         out_valid, stat_valid, tx_done_flag, tx_error_flag, irq;
   txp_word_t    out_word;
   txp_stat_t    stat, last_stat;
   logic [3:0]   last_be;
   logic [1:0]   al [3] = '{ALIGN_4, ALIGN_16, ALIGN_32};
   int           offs [2] = '{3, 31};
   int           szs [2] = '{2, 1};
   int           n_out, n_done, n_err, n_stat, exp_words;
   int           mismatches, compares;

   txp_parser u_dut (.sys_clk(sys_clk), .reset(reset), .in_valid(in_valid),
      .in_data(in_data), .out_valid(out_valid), .out_word(out_word),
      .stat_valid(stat_valid), .stat(stat), .tx_done_flag(tx_done_flag),
      .tx_error_flag(tx_error_flag), .irq(irq), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   txp_host_model u_host (.sys_clk(sys_clk), .in_valid(in_valid),
      .in_data(in_data));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ***************************************************
   // output monitor
   // ***************************************************
   always @(posedge sys_clk) begin
      if (out_valid === 1'b1) begin
         if (n_out == 0) first_data = out_word.data;
         last_be = out_word.be;
         n_out++;
      end
      if (tx_done_flag === 1'b1) n_done++;
      if (tx_error_flag === 1'b1) n_err++;
      if (stat_valid === 1'b1) begin
         n_stat++;
         last_stat = stat;
      end
   end

   // ***************************************************
   // tasks
   // ***************************************************
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   task automatic check(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR t=%0t %s", $time, what);
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 check(reg_rdata === e, "register read");
   endtask : reg_read

   task automatic wait_irq(input logic e);
      for (int i = 0; i < 8 && irq !== e; i++) @(posedge sys_clk);
      check(irq === e, "irq level");
      // a level that never arrives ends the run here
      if (irq !== e) stop_test;
   endtask : wait_irq

   function automatic txp_cmd_a_t mk_a(input logic ioc, fs, ls,
      input logic [1:0] a, input int off, sz);
      txp_cmd_a_t c;
      c = '0;
      c.ioc = ioc;
      c.first_segment_bit = fs;
      c.last = ls;
      c.align = a;
      c.offset = 5'(off);
      c.size = 11'(sz);
      return c;
   endfunction : mk_a

   function automatic txp_cmd_b_t mk_b(input logic [15:0] t, input int n);
      return {t, 5'h00, 11'(n)};
   endfunction : mk_b

   // clears the monitor, sends one buffer, lets the answers land
   task automatic send(input txp_cmd_a_t a, input txp_cmd_b_t b);
      n_out = 0;
      n_done = 0;
      n_err = 0;
      n_stat = 0;
      u_host.send_buf(a, b, 32'hb000_0000);
      exp_words += (a.offset + a.size + 3) / 4 - a.offset / 4;
      repeat (3) @(posedge sys_clk);
   endtask : send

   task automatic chk_data(input int off, sz);
      int e;
      logic [3:0] m;
      e = off + sz - 1;
      m = 4'hf >> (3 - e % 4);
      if (off / 4 == e / 4) m = m & (4'hf << (off % 4));
      check(n_out == (off + sz + 3) / 4 - off / 4, "stored word count");
      check(first_data === 32'hb000_0000 + off / 4, "first payload word");
      check(last_be === m, "last byte lanes");
   endtask : chk_data

   // ***************************************************
   // sequence
   // ***************************************************
   initial begin
      repeat (50000) @(posedge sys_clk);
      mismatches++;
      stop_test;
   end

   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      mismatches = 0;
      compares = 0;
      exp_words = 0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      send(mk_a(1, 1, 1, ALIGN_4, 0, 4), mk_b(16'h1234, 4));
      chk_data(0, 4);
      check(n_done == 1, "done pulse");
      check(n_stat == 1 && last_stat.tag === 16'h1234, "tag");
      $display("test single done");
      foreach (al[i]) begin
         send(mk_a(0, 1, 1, al[i], 0, 5), mk_b(16'h0002, 5));
         chk_data(0, 5);
         check(n_done == 0, "done without request");
      end
      $display("test alignment done");
      foreach (offs[i]) begin
         send(mk_a(0, 1, 1, ALIGN_32, offs[i], szs[i]),
              mk_b(16'h0003, szs[i]));
         chk_data(offs[i], szs[i]);
      end
      $display("test offset done");
      send(mk_a(0, 1, 0, ALIGN_4, 1, 3), mk_b(16'h5555, 8));
      check(n_stat == 0 && n_err == 0, "mid packet");
      send(mk_a(1, 0, 1, ALIGN_4, 0, 5), mk_b(16'h5555, 8));
      check(n_stat == 1 && n_err == 0, "packet end");
      check(last_stat.err === 1'b0, "status error bit");
      reg_read(REG_WORDS, 32'(exp_words[15:0]));
      reg_read(REG_TAG, 32'h0000_5555);
      $display("test two buffers done");
      send(mk_a(0, 1, 0, ALIGN_4, 0, 4), mk_b(16'h0007, 8));
      send(mk_a(0, 0, 1, ALIGN_4, 0, 4), mk_b(16'h0008, 8));
      check(n_err >= 1, "command B mismatch");
      send(mk_a(0, 1, 1, ALIGN_4, 0, 4), mk_b(16'h0009, 6));
      check(n_err == 1 && last_stat.err === 1'b1, "length error");
      $display("test errors done");
      reg_read(REG_INT_STS, 32'h3);
      wait_irq(1'b0);
      reg_write(REG_INT_EN, 32'h1);
      wait_irq(1'b1);
      reg_read(REG_INT_EN, 32'h1);
      reg_write(REG_INT_CLR, 32'h1);
      wait_irq(1'b0);
      reg_read(REG_INT_STS, 32'h2);
      send(mk_a(0, 1, 1, ALIGN_4, 0, 4), mk_b(16'h000a, 6));
      check(irq === 1'b0, "masked error");
      send(mk_a(1, 1, 1, ALIGN_16, 2, 7), mk_b(16'h000b, 7));
      wait_irq(1'b1);
      reg_write(REG_INT_CLR, 32'h3);
      wait_irq(1'b0);
      reg_read(8'h20, 32'h0);
      $display("test registers done");
      stop_test;
   end
endmodule : tb_tx_buffer_command_parser
